//--- design/cdb_consts.svh
// Timing, slot and encoding constants for the coupler data path buffer.
// Assumes a 100 MHz system clock and a 100 ns coupler clock period.
`ifndef CDB_CONSTS_SVH
`define CDB_CONSTS_SVH

`define CDB_CYC_NS 10
`define CDB_PERIOD_NS 100
`define CDB_PERIOD_CYC (`CDB_PERIOD_NS / `CDB_CYC_NS)
`define CDB_HALF_NS 50
`define CDB_HALF_CYC (`CDB_HALF_NS / `CDB_CYC_NS)
`define CDB_START_DLY_NS 500
`define CDB_START_DLY_CYC ((`CDB_START_DLY_NS + `CDB_CYC_NS - 1) / `CDB_CYC_NS)

`define CDB_SLOT_T25 4'h2
`define CDB_SLOT_T3 4'h3
`define CDB_SLOT_T1 4'h8

`define CDB_DATA_W 80
`define CDB_CNT_W 3
`define CDB_DEPTH 16
`define CDB_ADDR_W 4
`define CDB_Q_START 2'h2
`define CDB_FORCED_PARITY 1'h1
`define CDB_GO_FILL 1'h1

`define CDB_SY_GO 0
`define CDB_SY_ACC 1
`define CDB_SY_WR 2
`define CDB_SY_DOL 3
`define CDB_SY_ABORT 4
`define CDB_SY_CPE 5
`define CDB_SY_BPE 6
`define CDB_SY_N 7

`endif

//--- design/cdb_pkg.sv
// Types shared by the coupler data path buffer modules.
// Assumes cdb_consts.svh is on the include path.
`include "cdb_consts.svh"

package cdb_pkg;

  typedef logic [`CDB_ADDR_W-1:0] cdb_addr_t;
  typedef logic [3:0] cdb_slot_t;
  typedef logic [`CDB_SY_N-1:0] cdb_sync_t;

  typedef enum logic [1:0] {
    CDB_ST_IDLE,
    CDB_ST_PULSE,
    CDB_ST_HELD
  } cdb_start_e;

endpackage

//--- design/cdb_phase_gen.sv
// Coupler clock phase generator: slot counter, square wave and T pulses.
// Assumes one free running system clock and asynchronous reset.
`include "cdb_consts.svh"

module cdb_phase_gen
  import cdb_pkg::*;
#(
  parameter int PERIOD_CYC = `CDB_PERIOD_CYC,
  parameter int HALF_CYC = `CDB_HALF_CYC
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Phases.
  output cdb_slot_t slot_out,
  output logic sq_out,
  output logic t1_out,
  output logic t3_out,
  output logic t25_out
);

  localparam cdb_slot_t LAST = cdb_slot_t'(PERIOD_CYC - 1);
  localparam cdb_slot_t HALF = cdb_slot_t'(HALF_CYC);

  cdb_slot_t slot_reg;
  wire cdb_slot_t slot_next = (slot_reg == LAST) ? '0 : slot_reg + 4'h1;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      slot_reg <= '0;
    end else begin
      slot_reg <= slot_next;
    end
  end

  // The high half of the square wave is the input address half.
  assign slot_out = slot_reg;
  assign sq_out = slot_reg < HALF;
  assign t1_out = slot_reg == `CDB_SLOT_T1;
  assign t3_out = slot_reg == `CDB_SLOT_T3;
  assign t25_out = slot_reg == `CDB_SLOT_T25;

endmodule

//--- design/cdb_buf_mem.sv
// Sixteen word buffer RAM with one time shared address and registered read.
// Assumes the caller multiplexes input and output addresses by half period.
`include "cdb_consts.svh"

module cdb_buf_mem #(
  parameter int WIDTH = `CDB_DATA_W + 2,
  parameter int DEPTH = `CDB_DEPTH,
  parameter int AW = `CDB_ADDR_W
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Access port.
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // The array has no reset; a word is only read after it was written.
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem_reg[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_reg[addr_in];
    end
  end

endmodule

//--- design/cdb_coupler_data_path.sv
// Coupler data path: write FIFO toward the storage controller, read pass
// through toward central memory, record word countdown and address control.
// Assumes pin inputs are asynchronous; data pins are held steady while
// their qualifier is synchronised, so the data themselves are not.
`include "cdb_consts.svh"

// Contract
// - Hold next count on delayed go, accept, T3.
// - Preset countdown on accept, decrement each write T3.
// - Countdown zero clears the write-data flag.
// - Load-data is flag delayed 500 ns, square-gated.
// - Start delay only before first word of transfer.
// - Latch memory word and parity at T1.
// - Data-on-line makes 50 ns strobe writing buffer.
// - Block first request until two words buffered.
// - Further words stored at next address, up to 16.
// - Square wave halves share input and output address.
// - Each load-data advances output address, FIFO order.
// - Load-data fills holding register; send at T25.
// - Parity travels its own buffer with data; here it is a bit of the one buffer RAM word.
// - Every output word carries a go bit.
// - Read words pass through, clocked out at T3.
// - After read abort, force parity on zero words.
// - Capture controller and bank parity errors.
// - Transfer-go starts pulse ended by one-shot at T1.
// - Start pulse presets both addresses to zero.
// - Write strobe increments input address, wraps at 16.
// - Load-data increments output address.
module cdb_coupler_data_path
  import cdb_pkg::*;
#(
  parameter int DATA_W = `CDB_DATA_W,
  parameter int CNT_W = `CDB_CNT_W,
  parameter int START_DLY_CYC = `CDB_START_DLY_CYC
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Transfer control from the coupler.
  input wire logic transfer_go_in,
  input wire logic write_op_in,
  input wire logic [CNT_W-1:0] next_word_count_in,
  // Storage controller responses.
  input wire logic ctl_accept_in,
  input wire logic ctl_abort_in,
  input wire logic ctl_parity_err_in,
  input wire logic bank_parity_err_in,
  // Write direction from the central memory controller.
  input wire logic [DATA_W-1:0] cm_word_in,
  input wire logic cm_parity_in,
  input wire logic cm_data_on_line_in,
  // Write direction toward the storage controller.
  output logic [DATA_W-1:0] sc_word_out,
  output logic sc_parity_out,
  output logic sc_go_out,
  output logic req_enable_out,
  output logic load_data_out,
  // Read direction from the storage controller.
  input wire logic [DATA_W-1:0] sc_word_in,
  input wire logic sc_parity_in,
  // Read direction toward central memory.
  output logic [DATA_W-1:0] cm_word_out,
  output logic cm_parity_out,
  // Error register.
  output logic err_ctl_parity_out,
  output logic err_bank_parity_out
);

  localparam int MW = DATA_W + 2;
  localparam logic [7:0] DLY_MAX = 8'(START_DLY_CYC);
  localparam cdb_slot_t HALF_LAST = cdb_slot_t'(`CDB_HALF_CYC - 1);
  localparam cdb_slot_t LOAD_SLOT = cdb_slot_t'(`CDB_PERIOD_CYC - 1);

  // Phases.
  cdb_slot_t slot;
  logic sq;
  logic t1;
  logic t3;
  logic t25;

  cdb_phase_gen #(
    .PERIOD_CYC(`CDB_PERIOD_CYC),
    .HALF_CYC(`CDB_HALF_CYC)
  ) u_phase (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .slot_out(slot),
    .sq_out(sq),
    .t1_out(t1),
    .t3_out(t3),
    .t25_out(t25)
  );

  // Pin synchronisers; a change counts once stages two and three agree.
  cdb_sync_t sy1_reg;
  cdb_sync_t sy2_reg;
  cdb_sync_t sy3_reg;
  cdb_sync_t syf_reg;
  wire cdb_sync_t sy_raw = {bank_parity_err_in, ctl_parity_err_in,
    ctl_abort_in, cm_data_on_line_in, write_op_in, ctl_accept_in,
    transfer_go_in};
  wire cdb_sync_t sy_agree = ~(sy2_reg ^ sy3_reg);
  wire cdb_sync_t syf_next = (sy_agree & sy2_reg) | (~sy_agree & syf_reg);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
      sy3_reg <= '0;
      syf_reg <= '0;
    end else begin
      sy1_reg <= sy_raw;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      syf_reg <= syf_next;
    end
  end

  wire go_s = syf_reg[`CDB_SY_GO];
  wire acc_s = syf_reg[`CDB_SY_ACC];
  wire wr_s = syf_reg[`CDB_SY_WR];
  wire dol_s = syf_reg[`CDB_SY_DOL];
  wire abort_s = syf_reg[`CDB_SY_ABORT];

  // Start pulse and one-shot.
  cdb_start_e st_reg;
  cdb_start_e st_next;
  wire start_pulse = st_reg == CDB_ST_PULSE;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      CDB_ST_IDLE: if (go_s) st_next = CDB_ST_PULSE;
      CDB_ST_PULSE: if (t1) st_next = CDB_ST_HELD;
      CDB_ST_HELD: if (!go_s) st_next = CDB_ST_IDLE;
      default: st_next = CDB_ST_IDLE;
    endcase
  end

  // Write strobe: a word latched at T1 is written in the next input half.
  logic [MW-1:0] in_hold_reg;
  logic pend_reg;
  wire capture = t1 && dol_s;
  wire wr_strobe = pend_reg && sq;
  wire mem_we = wr_strobe && (slot == HALF_LAST);

  // Addresses.
  cdb_addr_t in_addr_reg;
  cdb_addr_t out_addr_reg;
  logic load_data;
  wire cdb_addr_t mem_addr = sq ? in_addr_reg : out_addr_reg;
  wire [MW-1:0] mem_rdata;

  cdb_buf_mem #(
    .WIDTH(MW),
    .DEPTH(`CDB_DEPTH),
    .AW(`CDB_ADDR_W)
  ) u_mem (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .we_in(mem_we),
    .addr_in(mem_addr),
    .wdata_in(in_hold_reg),
    .rdata_out(mem_rdata)
  );

  // Buffered-word count and first request blocking.
  logic [1:0] q_cnt_reg;
  logic req_ok_reg;
  wire q_reached = q_cnt_reg == `CDB_Q_START;

  // Record word countdown and write-data flag.
  logic [CNT_W-1:0] p_hold_reg;
  logic [CNT_W-1:0] pdc_reg;
  logic wflag_reg;
  logic [7:0] dly_cnt_reg;
  wire dly_done = dly_cnt_reg == DLY_MAX;
  wire hold_cnt = st_reg == CDB_ST_HELD && acc_s && t3;
  wire pdc_dec = !acc_s && wr_s && t3 && pdc_reg != '0;
  wire wflag_set = wr_s && acc_s;
  wire wflag_clr = pdc_dec && pdc_reg == CNT_W'(1);

  // Load-data comes once per period at the end of the output half.
  assign load_data = wflag_reg && dly_done && !sq
    && (slot == LOAD_SLOT);

  // Outgoing holding register and transmit gating.
  logic [MW-1:0] out_hold_reg;
  logic fresh_reg;
  wire xmit_data = wr_s && sq;
  wire send = t25 && xmit_data && fresh_reg;

  // Read direction holding registers and abort tracking.
  logic [DATA_W-1:0] rd_hold_reg;
  logic rd_par_hold_reg;
  logic abort_reg;
  logic [1:0] err_hold_reg;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg <= CDB_ST_IDLE;
      in_hold_reg <= '0;
      pend_reg <= 1'b0;
      in_addr_reg <= '0;
      out_addr_reg <= '0;
      q_cnt_reg <= '0;
      req_ok_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (capture) begin
        // The go section of each word is written as ones.
        in_hold_reg <= {`CDB_GO_FILL, cm_parity_in,
          cm_word_in};
      end
      if (capture) begin
        pend_reg <= 1'b1;
      end else if (mem_we) begin
        pend_reg <= 1'b0;
      end
      if (start_pulse) begin
        in_addr_reg <= '0;
        out_addr_reg <= '0;
      end else begin
        // Natural wrap of the four bit address after sixteen words.
        if (mem_we) in_addr_reg <= in_addr_reg + 4'h1;
        if (load_data) out_addr_reg <= out_addr_reg + 4'h1;
      end
      if (start_pulse) begin
        q_cnt_reg <= '0;
      end else if (mem_we && !q_reached) begin
        q_cnt_reg <= q_cnt_reg + 2'h1;
      end
      if (start_pulse) begin
        req_ok_reg <= 1'b0;
      end else if (!wr_s || q_reached) begin
        req_ok_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      p_hold_reg <= '0;
      pdc_reg <= '0;
      wflag_reg <= 1'b0;
      dly_cnt_reg <= '0;
    end else begin
      if (hold_cnt) p_hold_reg <= next_word_count_in;
      if (acc_s) begin
        pdc_reg <= p_hold_reg;
      end else if (pdc_dec) begin
        pdc_reg <= pdc_reg - CNT_W'(1);
      end
      // A new accept wins over the end of the previous record.
      if (wflag_set) begin
        wflag_reg <= 1'b1;
      end else if (wflag_clr) begin
        wflag_reg <= 1'b0;
      end
      // The delay is rearmed only by a new transfer, so a flag drop
      // between records costs no more than the gap itself.
      if (start_pulse) begin
        dly_cnt_reg <= '0;
      end else if (wflag_reg && !dly_done) begin
        dly_cnt_reg <= dly_cnt_reg + 8'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      out_hold_reg <= '0;
      fresh_reg <= 1'b0;
      sc_word_out <= '0;
      sc_parity_out <= 1'b0;
      sc_go_out <= 1'b0;
    end else begin
      if (load_data) out_hold_reg <= mem_rdata;
      if (load_data) begin
        fresh_reg <= 1'b1;
      end else if (send) begin
        fresh_reg <= 1'b0;
      end
      if (send) begin
        sc_word_out <= out_hold_reg[DATA_W-1:0];
        sc_parity_out <= out_hold_reg[DATA_W];
        sc_go_out <= out_hold_reg[DATA_W+1];
      end else if (t25) begin
        sc_go_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_hold_reg <= '0;
      rd_par_hold_reg <= 1'b0;
      cm_word_out <= '0;
      cm_parity_out <= 1'b0;
      abort_reg <= 1'b0;
      err_hold_reg <= '0;
    end else begin
      rd_hold_reg <= sc_word_in;
      rd_par_hold_reg <= sc_parity_in;
      if (t3) begin
        cm_word_out <= rd_hold_reg;
        cm_parity_out <= abort_reg ? `CDB_FORCED_PARITY
          : rd_par_hold_reg;
      end
      if (abort_s && !wr_s) begin
        abort_reg <= 1'b1;
      end else if (start_pulse) begin
        abort_reg <= 1'b0;
      end
      err_hold_reg <= {syf_reg[`CDB_SY_BPE], syf_reg[`CDB_SY_CPE]};
    end
  end

  assign req_enable_out = req_ok_reg && !start_pulse;
  assign load_data_out = load_data;
  assign err_ctl_parity_out = err_hold_reg[0];
  assign err_bank_parity_out = err_hold_reg[1];

  // Checks.
  AST_PRESET: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    start_pulse |=> in_addr_reg == '0 && out_addr_reg == '0)
    else $error("Addresses not preset by start pulse.");

  AST_IN_INC: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    mem_we && !start_pulse |=> in_addr_reg == $past(in_addr_reg) + 4'h1)
    else $error("Input address did not advance on write.");

  AST_OUT_INC: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    load_data && !start_pulse |=> out_addr_reg == $past(out_addr_reg) + 4'h1)
    else $error("Output address did not advance on load.");

  AST_STROBE_LEN: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(wr_strobe) |-> wr_strobe [*5] ##1 !wr_strobe)
    else $error("Write strobe is not five cycles long.");

  AST_REQ_BLOCK: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(req_enable_out) && wr_s |-> q_cnt_reg == `CDB_Q_START)
    else $error("Request enabled before two words buffered.");

  AST_PDC_PRESET: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    acc_s |=> pdc_reg == $past(p_hold_reg))
    else $error("Countdown not preset from held count.");

  AST_FLAG_END: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    wflag_clr && !wflag_set |=> !wflag_reg && pdc_reg == '0)
    else $error("Write-data flag not cleared at count zero.");

  AST_LOAD_DELAY: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    load_data |-> wflag_reg && dly_cnt_reg == DLY_MAX && !sq)
    else $error("Load-data before start delay elapsed.");

  AST_RD_PASS: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    t3 |=> cm_word_out == $past(rd_hold_reg))
    else $error("Read word not passed at T3.");

  AST_FORCE_PAR: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    t3 && abort_reg |=> cm_parity_out == `CDB_FORCED_PARITY)
    else $error("Forced parity missing after abort.");

  AST_PULSE_END: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(start_pulse) |-> ##[1:10] !start_pulse)
    else $error("Start pulse outlived one coupler period.");

endmodule

//--- testbench/cdb_far_side.sv
// Far side model: central memory word source and storage controller accept.
// Assumes slot_in counts the ten system cycles of each coupler period.
module cdb_far_side
  import cdb_pkg::*;
(
  // Clock, reset and phase.
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [3:0] slot_in,
  // Coupler side.
  input wire logic stream_in,
  input wire logic req_enable_in,
  input wire logic load_data_in,
  // Pins toward the coupler.
  output logic [79:0] cm_word_out,
  output logic cm_parity_out,
  output logic cm_data_on_line_out,
  output logic ctl_accept_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] n_sent;
  initial ctl_accept_out = 1'h0;
  // Words change in slot 2, well clear of the T1 capture; idle lines are
  // inverted so that a stale word never looks like a fresh one.
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      n_sent <= 8'h00;
      cm_word_out <= 80'h0;
      cm_parity_out <= 1'h0;
      cm_data_on_line_out <= 1'h0;
    end else if (slot_in == 4'h1 && stream_in) begin
      cm_word_out <= {10{n_sent}};
      cm_parity_out <= n_sent[0];
      cm_data_on_line_out <= 1'h1;
      n_sent <= n_sent + 8'h01;
    end else if (slot_in == 4'h1) begin
      cm_word_out <= ~cm_word_out;
      cm_parity_out <= ~cm_parity_out;
      cm_data_on_line_out <= 1'h0;
    end
  end
  // One record: wait for the request, stall for some periods, accept for
  // one period, then hold off until the loads of the record have stopped.
  // Accept rises in slot 7 so that T3 falls inside the synchronised accept
  // before its last cycle; the countdown then presets from this count.
  task automatic give_record(input int slow);
    int gap;
    logic seen;
    gap = 0;
    seen = 1'h0;
    while (req_enable_in !== 1'h1) @(posedge clk_sys_in);
    repeat (slow * 10) @(posedge clk_sys_in);
    while (slot_in != 4'h6) @(posedge clk_sys_in);
    ctl_accept_out <= 1'h1;
    repeat (10) @(posedge clk_sys_in);
    ctl_accept_out <= 1'h0;
    while (gap < 12) begin
      @(posedge clk_sys_in);
      seen = seen | load_data_in;
      gap = (seen && !load_data_in) ? gap + 1 : 0;
    end
  endtask
endmodule

//--- testbench/coupler_data_path_buffer_bench.sv
// Self-checking bench: write stream through the buffer, read pass through
// with abort and error pins, and reset.
// Assumes cdb_pkg, the design modules and cdb_far_side are compiled first.
module coupler_data_path_buffer_bench
  import cdb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DLY = 25;
  typedef struct packed {
    logic [79:0] word;
    logic par;
    logic abort;
    logic cpe;
    logic bpe;
  } cdb_row_s;
  // The last three rows are the zero fill that follows an abort.
  cdb_row_s rows [6] = '{
    '{80'h0123_4567_89ab_cdef_0f1e, 1'h1, 1'h0, 1'h0, 1'h0},
    '{80'hffff_0000_ffff_0000_a5a5, 1'h0, 1'h0, 1'h1, 1'h0},
    '{80'h8000_0000_0000_0000_0001, 1'h1, 1'h0, 1'h0, 1'h1},
    '{80'h0, 1'h0, 1'h1, 1'h0, 1'h0},
    '{80'h0, 1'h0, 1'h1, 1'h1, 1'h1},
    '{80'h0, 1'h0, 1'h1, 1'h0, 1'h0}};
  int counts [4] = '{7, 2, 7, 7};
  cdb_row_s p;
  logic clk_sys_in = 1'h0;
  logic reset_in = 1'h1;
  logic transfer_go_in = 1'h0;
  logic write_op_in = 1'h0;
  logic ctl_abort_in = 1'h0;
  logic ctl_parity_err_in = 1'h0;
  logic bank_parity_err_in = 1'h0;
  logic stream_en = 1'h0;
  logic rec_first = 1'h0;
  logic ok;
  logic [2:0] next_word_count_in = 3'h0;
  logic [79:0] sc_word_in = 80'h0;
  logic sc_parity_in = 1'h0;
  logic [79:0] cm_word_in, sc_word_out, cm_word_out;
  logic cm_parity_in, cm_data_on_line_in, ctl_accept_in;
  logic sc_parity_out, sc_go_out, req_enable_out, load_data_out;
  logic cm_parity_out, err_ctl_parity_out, err_bank_parity_out;
  int cyc, num_errors, n_compared, n_loads, n_chk, acc_cyc, lat, m;
  wire logic [3:0] slot = 4'(cyc % 10);
  // The source pauses when twelve words wait, so the buffer never laps.
  wire logic stream = stream_en && (8'(far.n_sent - n_chk) < 8'h0c);

  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  cdb_coupler_data_path #(.START_DLY_CYC(DLY)) dut (
    .clk_sys_in, .reset_in, .transfer_go_in, .write_op_in,
    .next_word_count_in, .ctl_accept_in, .ctl_abort_in, .ctl_parity_err_in,
    .bank_parity_err_in, .cm_word_in, .cm_parity_in, .cm_data_on_line_in,
    .sc_word_out, .sc_parity_out, .sc_go_out, .req_enable_out,
    .load_data_out, .sc_word_in, .sc_parity_in, .cm_word_out,
    .cm_parity_out, .err_ctl_parity_out, .err_bank_parity_out);
  cdb_far_side far (
    .clk_sys_in, .reset_in, .slot_in(slot), .stream_in(stream),
    .req_enable_in(req_enable_out), .load_data_in(load_data_out),
    .cm_word_out(cm_word_in), .cm_parity_out(cm_parity_in),
    .cm_data_on_line_out(cm_data_on_line_in),
    .ctl_accept_out(ctl_accept_in));

  task automatic check(input string what, input logic [79:0] exp,
                       input logic [79:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic to_slot(input int s);
    @(posedge clk_sys_in);
    while (cyc % 10 != s) @(posedge clk_sys_in);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge ctl_accept_in) begin
    acc_cyc = cyc;
    rec_first = 1'h1;
  end

  always @(posedge clk_sys_in) begin
    if (!reset_in && load_data_out === 1'h1) begin
      n_loads++;
      if (rec_first) begin
        lat = cyc - acc_cyc;
        rec_first = 1'h0;
      end
      repeat (3) @(posedge clk_sys_in);
      #1;
      check("sc_word_out", {10{8'(n_chk)}}, sc_word_out);
      check("sc_parity_out", 80'(n_chk % 2), 80'(sc_parity_out));
      check("sc_go_out", 80'h1, 80'(sc_go_out));
      n_chk++;
    end
  end

  initial begin
    repeat (11) @(posedge clk_sys_in);
    #1;
    check("sc_word_out", 80'h0, sc_word_out);
    check("req_enable_out", 80'h0, 80'(req_enable_out));
    @(posedge clk_sys_in);
    reset_in <= 1'h0;
    to_slot(4);
    write_op_in <= 1'h1;
    transfer_go_in <= 1'h1;
    repeat (30) @(posedge clk_sys_in);
    to_slot(0);
    stream_en <= 1'h1;
    repeat (20) @(posedge clk_sys_in);
    #1;
    check("req_enable_out", 80'h0, 80'(req_enable_out));
    repeat (10) @(posedge clk_sys_in);
    #1;
    check("req_enable_out", 80'h1, 80'(req_enable_out));
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_sys_in);
      next_word_count_in <= 3'(counts[r]);
      m = n_loads;
      far.give_record(r == 0 ? 1 : 0);
      ok = n_loads - m >= counts[r] && n_loads - m <= counts[r] + 2;
      if (r == 0) begin
        check("start delay", 80'h1, 80'(lat >= DLY));
      end else begin
        check("record delay", 80'h1, 80'(lat <= 20));
        check("record loads", 80'h1, 80'(ok));
      end
    end
    stream_en <= 1'h0;
    transfer_go_in <= 1'h0;
    write_op_in <= 1'h0;
    repeat (30) @(posedge clk_sys_in);
    #1;
    check("sc_go_out idle", 80'h0, 80'(sc_go_out));
    transfer_go_in <= 1'h1;
    repeat (30) @(posedge clk_sys_in);
    #1;
    check("req_enable_out", 80'h1, 80'(req_enable_out));
    for (int i = 0; i <= 6; i++) begin
      to_slot(4);
      if (i < 6) begin
        sc_word_in <= rows[i].word;
        sc_parity_in <= rows[i].par;
        ctl_abort_in <= rows[i].abort;
        ctl_parity_err_in <= rows[i].cpe;
        bank_parity_err_in <= rows[i].bpe;
      end
      #1;
      if (i > 0) begin
        p = rows[i - 1];
        check("cm_word_out", p.word, cm_word_out);
        check("cm_parity_out", 80'(p.par | p.abort), 80'(cm_parity_out));
        check("err_ctl", 80'(p.cpe), 80'(err_ctl_parity_out));
        check("err_bank", 80'(p.bpe), 80'(err_bank_parity_out));
      end
    end
    @(posedge clk_sys_in);
    reset_in <= 1'h1;
    #1;
    check("cm_word_out", 80'h0, cm_word_out);
    check("err_ctl", 80'h0, 80'(err_ctl_parity_out));
    check("cm_parity_out", 80'h0, 80'(cm_parity_out));
    end_of_test();
  end

  // The whole run takes about 600 cycles; ten times that means a hang.
  initial begin
    repeat (6000) @(posedge clk_sys_in);
    num_errors++;
    end_of_test();
  end
endmodule
